// ===== core/acsio_map.svh
`ifndef ACSIO_MAP_SVH
`define ACSIO_MAP_SVH

// Configuration word layout, shifted in MSB first, last bits on the wire.
`define ACSIO_CFG_W 8
`define ACSIO_CFG_CHAN_LSB 0
`define ACSIO_CFG_CHAN_W 4
`define ACSIO_CFG_LEN_LSB 4
`define ACSIO_CFG_MODE_LSB 6

// Mode codes held in the configuration word.
`define ACSIO_MODE_CONVERT 2'h0
`define ACSIO_MODE_CAL 2'h1
`define ACSIO_MODE_ZERO 2'h2
`define ACSIO_MODE_PDOWN 2'h3

// Word length codes and the lengths they select.
`define ACSIO_LEN_W 5
`define ACSIO_LEN_DEFAULT 5'h0D
`define ACSIO_LEN_CODE1 5'h11
`define ACSIO_LEN_CODE2 5'h09
`define ACSIO_LEN_MAX 17

// Timing: acquisition time in ns and the clock rate in MHz.
`define ACSIO_ACQ_NS 250
`define ACSIO_CLK_MHZ 40
`define ACSIO_ACQ_CYC ((`ACSIO_ACQ_NS * `ACSIO_CLK_MHZ + 999) / 1000)

`endif

// ===== core/acsio_pkg.sv
package acsio_pkg;

  // Converter sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACQ,
    ST_PROGRAM_ENABLE_N,
    ST_CAL,
    ST_PDOWN
  } acsio_state_t;

  // Decoded configuration word.
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] len_sel;
    logic [3:0] chan;
  } acsio_cfg_t;

  // Status presented to the system side.
  typedef struct packed {
    logic done;
    logic [1:0] mode;
    logic [3:0] chan;
  } acsio_status_t;

endpackage : acsio_pkg

// ===== core/acsio_sync.sv
`timescale 1ns/10ps

module acsio_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Levels from another domain and their synchronised copies.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Two stages; the first is read by the second only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : acsio_sync

// ===== core/acsio_link.sv
`timescale 1ns/10ps
`include "acsio_map.svh"

module acsio_link #(
  parameter int OUT_W = `ACSIO_LEN_MAX
) (
  // Serial clock domain and resets.
  input wire logic sclk,
  input wire logic reset_n,
  input wire logic restart,
  // Serial pins.
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic output_ready_flag,
  // Quasi-static values from the conversion side.
  input wire logic [OUT_W-1:0] word_in,
  input wire logic [`ACSIO_LEN_W-1:0] word_len,
  // Received configuration, qualified by a toggle.
  output logic [`ACSIO_CFG_W-1:0] cfg_word,
  output logic cfg_tgl
);

  logic frame_rst;
  logic rdy_rst_n;
  logic [`ACSIO_LEN_W-1:0] rx_cnt_q;
  logic [`ACSIO_LEN_W-1:0] tx_cnt_q;
  logic [`ACSIO_LEN_W-1:0] tx_cnt_nx;
  logic [`ACSIO_CFG_W-1:0] cfg_shift_q;
  logic [OUT_W-1:0] tx_shift_q;
  logic loaded_q;

  // A frame ends when select rises or a new result restarts the read.
  assign frame_rst = cs_n | restart;
  assign rdy_rst_n = reset_n & ~restart;

  // Output drives only while selected.
  assign serial_out_oe = ~cs_n;
  // Before the first falling edge the first bit comes straight from the word.
  assign serial_out = loaded_q ? tx_shift_q[OUT_W-1] : word_in[OUT_W-1];

  // Bit count of the frame; length follows the configured word.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rx_cnt_q <= '0;
    end else if (rx_cnt_q == word_len - 5'h01) begin
      rx_cnt_q <= '0;
    end else begin
      rx_cnt_q <= rx_cnt_q + 5'h01;
    end
  end

  // Sample the serial input on rising edges; publish at the last bit.
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_shift_q <= '0;
      cfg_word <= '0;
      cfg_tgl <= 1'b0;
    end else begin
      cfg_shift_q <= {cfg_shift_q[`ACSIO_CFG_W-2:0], serial_in};
      if (rx_cnt_q == word_len - 5'h01) begin
        cfg_word <= {cfg_shift_q[`ACSIO_CFG_W-2:0], serial_in};
        cfg_tgl <= ~cfg_tgl;
      end
    end
  end

  // Saturating count of bits already on the line.
  assign tx_cnt_nx = (tx_cnt_q == word_len) ? tx_cnt_q : tx_cnt_q + 5'h01;

  // Falling edges shift the following result bits out.
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      loaded_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_shift_q <= '0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      tx_cnt_q <= 5'h01;
      tx_shift_q <= {word_in[OUT_W-2:0], 1'b0};
    end else begin
      tx_cnt_q <= tx_cnt_nx;
      tx_shift_q <= {tx_shift_q[OUT_W-2:0], 1'b0};
    end
  end

  // Low while bits are going out, high once the whole word has gone.
  // A fresh result under continuous select pulls it low again so the host sees data pending.
  always_ff @(negedge sclk or negedge rdy_rst_n) begin
    if (!rdy_rst_n) begin
      output_ready_flag <= 1'b0;
    end else if (!cs_n) begin
      output_ready_flag <= (loaded_q ? tx_cnt_nx : 5'h01) == word_len;
    end
  end

endmodule : acsio_link

// ===== core/acsio_top.sv
`timescale 1ns/10ps
`include "acsio_map.svh"

module acsio_top
  import acsio_pkg::*;
#(
  parameter int RES_W = 13,
  parameter int OUT_W = `ACSIO_LEN_MAX,
  parameter int CAL_CYC = 64
) (
  // Conversion clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial link.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic output_ready_flag,
  // Control from the system.
  input wire logic program_enable_n,
  // Digitised value from the analog front end.
  input wire logic [RES_W-1:0] program_enable_n_value,
  // Status to the analog side.
  output logic conversion_done,
  output logic [3:0] mux_channel,
  output logic [1:0] program_enable_n_mode
);

  // One shared down counter serves acquisition, conversion and calibration.
  // Sixteen bits cover the longest calibration count that is accepted.
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] ACQ_LOAD = CNT_W'(`ACSIO_ACQ_CYC - 1);
  localparam logic [CNT_W-1:0] PROGRAM_ENABLE_N_LOAD = CNT_W'(RES_W - 1);
  localparam logic [CNT_W-1:0] CAL_LOAD = CNT_W'(CAL_CYC - 1);

  // Loads are one less than the span because the state that counts them
  // down also spends a cycle at zero before it moves on.

  // Refuse shapes the shifter cannot carry.
  if (RES_W > OUT_W || RES_W < 2 || OUT_W > 31) begin : g_bad_width
    $error("acsio_top: result width does not fit the output word");
  end
  if (CAL_CYC < 1 || CAL_CYC > 65535) begin : g_bad_cal
    $error("acsio_top: calibration count out of range");
  end
  if (`ACSIO_LEN_MAX > OUT_W) begin : g_bad_len
    $error("acsio_top: longest word length exceeds the output word");
  end
  if (`ACSIO_ACQ_CYC < 1 || `ACSIO_ACQ_CYC > 65535) begin : g_bad_acq
    $error("acsio_top: acquisition count does not fit the counter");
  end
  if (`ACSIO_CFG_W != $bits(acsio_cfg_t)) begin : g_bad_cfg
    $error("acsio_top: configuration word and its fields disagree");
  end

  // Whole state of the conversion side.
  typedef struct packed {
    acsio_state_t fsm;
    logic [CNT_W-1:0] cnt;
    acsio_status_t stat;
    logic [`ACSIO_LEN_W-1:0] len;
    logic [RES_W-1:0] result;
    logic restart;
    logic frame_seen;
    logic cs_prev;
  } acsio_core_t;

  // Everything on the conversion side lives in one record, so a single
  // register stage and a single next-state process cover it; a new field
  // needs no new process.
  acsio_core_t s_q;
  acsio_core_t s_d;

  // Signals from the serial clock domain are read here only after two
  // flip-flops, except the configuration word, which the link holds still
  // until its toggle has crossed.
  logic rst_meta_q;
  logic rst_n_q;
  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic cs_n_s;
  logic prog_n_s;
  logic cfg_tgl_s;
  logic cfg_tgl;
  logic [`ACSIO_CFG_W-1:0] cfg_word;
  acsio_cfg_t cfg;
  logic frame_evt;
  logic cs_fall;
  logic [OUT_W-1:0] word_out;
  logic [`ACSIO_LEN_W-1:0] len_dec;

  // Reset asserts at once and releases through two flip-flops.
  // Assertion stays asynchronous so a stopped clock cannot hold it off,
  // while release lands on one edge for every flop of this domain.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Select, program enable and the config toggle cross into clk_sys.
  // Reset values match the idle pins: deselected, read only and nothing
  // pending, so no false edge follows reset.
  assign sync_in = {cfg_tgl, program_enable_n, cs_n};

  acsio_sync #(
    .WIDTH(3),
    .RST_VAL(3'h3)
  ) u_sync (
    .clk(clk_sys),
    .rst_n(rst_n_q),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  assign cs_n_s = sync_out[0];
  assign prog_n_s = sync_out[1];
  assign cfg_tgl_s = sync_out[2];

  // The config word is stable long before its toggle arrives here.
  // A toggle rather than a pulse is sent, so a fast serial clock can
  // never make the event too short to be seen.
  assign cfg = acsio_cfg_t'(cfg_word);
  assign frame_evt = cfg_tgl_s ^ s_q.frame_seen;
  assign cs_fall = s_q.cs_prev & ~cs_n_s;

  // Result leaves MSB first, left justified in the longest word.
  // A shorter word simply stops early and drops the low bits.
  assign word_out = {s_q.result, {(OUT_W-RES_W){1'b0}}};

  // Word length decode; unused codes keep the power-up length.
  // The decoded length is taken into the state only when a frame is
  // accepted, so a refused frame cannot change the count.
  always_comb begin
    case (cfg.len_sel)
      2'h1: len_dec = `ACSIO_LEN_CODE1;
      2'h2: len_dec = `ACSIO_LEN_CODE2;
      default: len_dec = `ACSIO_LEN_DEFAULT;
    endcase
  end

  // Sequencer, counted on clk_sys so the serial clock never times it.
  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.frame_seen = cfg_tgl_s;
    s_d.cs_prev = cs_n_s;
    case (s_q.fsm)
      ST_IDLE, ST_PDOWN: begin
        // Only idle and power down accept a frame; calibration ignores it, and a conversion is cut short below.
        // In read-only mode a frame only reads; nothing else moves.
        if (frame_evt && !prog_n_s) begin
          s_d.stat.chan = cfg.chan;
          s_d.stat.mode = cfg.mode;
          s_d.len = len_dec;
          s_d.stat.done = 1'b0;
          case (cfg.mode)
            `ACSIO_MODE_CONVERT: begin
              s_d.fsm = ST_ACQ;
              s_d.cnt = ACQ_LOAD;
            end
            `ACSIO_MODE_PDOWN: begin
              // Power down holds done low until a working mode is loaded.
              s_d.fsm = ST_PDOWN;
            end
            default: begin
              s_d.fsm = ST_CAL;
              s_d.cnt = CAL_LOAD;
            end
          endcase
        end
      end
      ST_ACQ: begin
        // Acquisition runs for a fixed count of conversion clocks.
        if (s_q.cnt == '0) begin
          s_d.fsm = ST_PROGRAM_ENABLE_N;
          s_d.cnt = PROGRAM_ENABLE_N_LOAD;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      ST_PROGRAM_ENABLE_N: begin
        // One conversion clock per result bit, then the value is taken.
        if (s_q.cnt == '0) begin
          s_d.fsm = ST_IDLE;
          s_d.result = program_enable_n_value;
          s_d.stat.done = 1'b1;
          // Under continuous select the new word restarts the read.
          s_d.restart = ~cs_n_s;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      ST_CAL: begin
        // Calibration and zeroing share one timed wait; only the mode differs.
        if (s_q.cnt == '0) begin
          s_d.fsm = ST_IDLE;
          s_d.stat.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      default: begin
        // An unused state code falls back to idle and reports done.
        s_d.fsm = ST_IDLE;
        s_d.stat.done = 1'b1;
      end
    endcase
    // A new frame cuts a running conversion short; its data is stale.
    // Calibration and power down are not cut short; only a conversion is.
    // The result register keeps the older value, so a host that ignores
    // the aborted read still gets a whole word next time.
    if (cs_fall && (s_q.fsm == ST_ACQ || s_q.fsm == ST_PROGRAM_ENABLE_N)) begin
      s_d.fsm = ST_IDLE;
      s_d.stat.done = 1'b1;
    end
  end

  // One register stage for the whole conversion side.
  // The reset record mirrors power-up: idle, done high, default length.
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '{
        fsm: ST_IDLE,
        cnt: '0,
        stat: '{done: 1'b1, mode: `ACSIO_MODE_CONVERT, chan: 4'h0},
        len: `ACSIO_LEN_DEFAULT,
        result: '0,
        restart: 1'b0,
        frame_seen: 1'b0,
        cs_prev: 1'b1
      };
    end else begin
      s_q <= s_d;
    end
  end

  // Status outputs come straight from the state register, so they never
  // glitch while the next state settles.
  assign conversion_done = s_q.stat.done;
  assign mux_channel = s_q.stat.chan;
  assign program_enable_n_mode = s_q.stat.mode;

  // Serial-clock side of the port.
  // The result word and length are held still between conversions, so
  // they cross without a handshake. A limitation: changing the length
  // while a frame is in flight gives that frame a mixed count, so hosts
  // should change it only between frames.
  acsio_link #(
    .OUT_W(OUT_W)
  ) u_link (
    .sclk(sclk),
    .reset_n(reset_n),
    .restart(s_q.restart),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .output_ready_flag(output_ready_flag),
    .word_in(word_out),
    .word_len(s_q.len),
    .cfg_word(cfg_word),
    .cfg_tgl(cfg_tgl)
  );

endmodule : acsio_top

// ===== test/acsio_top_sva.sv
`timescale 1ns/10ps

module acsio_top_chk #(
  parameter int RES_W = 13,
  parameter int OUT_W = 17,
  parameter int CAL_CYC = 64
) (
  // Clocks and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sclk,
  // Serial link.
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic output_ready_flag,
  // Control and status.
  input wire logic program_enable_n,
  input wire logic [RES_W-1:0] program_enable_n_value,
  input wire logic conversion_done,
  input wire logic [3:0] mux_channel,
  input wire logic [1:0] program_enable_n_mode
);
  localparam int BUSY_MAX = 16 + RES_W + CAL_CYC;
  logic [4:0] nfall_q;
  logic [7:0] busy_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Falling serial clocks since select went low; cleared while deselected.
  // Reset clears it too, so the first frame never counts from unknown.
  always_ff @(negedge sclk or posedge cs_n or negedge reset_n) begin
    if (cs_n || !reset_n) nfall_q <= 5'h00;
    else nfall_q <= nfall_q + 5'h01;
  end

  // Busy cycles; power down is left out since it may last for ever.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) busy_q <= 8'h00;
    else if (conversion_done || program_enable_n_mode == 2'h3) busy_q <= 8'h00;
    else if (busy_q != 8'hFF) busy_q <= busy_q + 8'h01;
  end

  sequence s_start;
    $fell(conversion_done) && cs_n;
  endsequence
  sequence s_hold;
    (!conversion_done || !cs_n) [*8];
  endsequence

  property p_oe_on; !cs_n |-> serial_out_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("data driver off while selected");
  property p_oe_off; cs_n |-> !serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data driver on while deselected");
  property p_ready_len;
    $rose(output_ready_flag) |-> nfall_q inside {5'h09, 5'h0D, 5'h11};
  endproperty
  a_ready_len: assert property (p_ready_len)
    else $error("ready rose after a wrong clock count");
  property p_ready_low;
    !cs_n && nfall_q inside {[5'h01:5'h08]} |-> !output_ready_flag;
  endproperty
  a_ready_low: assert property (p_ready_low)
    else $error("ready high in mid word");
  property p_busy_min; s_start |-> s_hold; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy period too short");
  property p_busy_max; busy_q <= BUSY_MAX; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy period never ends");
  property p_abort;
    $fell(cs_n) && !conversion_done && program_enable_n_mode == 2'h0 &&
      !program_enable_n |-> ##[1:8] conversion_done;
  endproperty
  a_abort: assert property (p_abort)
    else $error("select fall did not abort conversion");
  property p_ro_hold;
    program_enable_n [*8] |=> $stable(mux_channel) && $stable(program_enable_n_mode)
      && !$fell(conversion_done);
  endproperty
  a_ro_hold: assert property (p_ro_hold)
    else $error("read only mode changed state");
endmodule : acsio_top_chk

bind acsio_top acsio_top_chk #(.RES_W(RES_W), .OUT_W(OUT_W),
  .CAL_CYC(CAL_CYC)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .output_ready_flag(output_ready_flag),
  .program_enable_n(program_enable_n), .program_enable_n_value(program_enable_n_value),
  .conversion_done(conversion_done), .mux_channel(mux_channel),
  .program_enable_n_mode(program_enable_n_mode));

// ===== test/acsio_host.sv
`timescale 1ns/10ps

module acsio_host (
  // Serial pins towards the converter.
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  // Resolved data line.
  input wire logic sdata
);
  logic [16:0] got;

  // Idle: clock parked low, select high.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    got = '0;
  end

  // One frame of n clocks; the last eight input bits carry cfg, MSB first.
  task automatic frame(input logic [7:0] cfg, input int n);
    logic b;
    b = 1'b0;
    #7 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = (i >= n - 8) ? cfg[n - 1 - i] : 1'b0;
      serial_in = b;
      #40 sclk = 1'b1;
      got = {got[15:0], sdata};
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // A released input line shows the inverse, not the last value.
    serial_in = ~b;
  endtask : frame
endmodule : acsio_host

// ===== test/acsio_top_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module acsio_top_tb;
  logic clk_sys, reset_n, program_enable_n;
  logic serial_out, serial_out_oe, output_ready_flag, conversion_done;
  logic [12:0] program_enable_n_value;
  logic [3:0] mux_channel;
  logic [1:0] program_enable_n_mode;
  wire sclk, cs_n, serial_in, sdata;
  int bad_count, compares, cyc, starts;

  // The data line floats unless the converter drives it.
  assign sdata = serial_out_oe ? serial_out : 1'bz;

  acsio_top #(.CAL_CYC(12)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .output_ready_flag(output_ready_flag),
    .program_enable_n(program_enable_n), .program_enable_n_value(program_enable_n_value),
    .conversion_done(conversion_done), .mux_channel(mux_channel),
    .program_enable_n_mode(program_enable_n_mode));
  acsio_host host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .sdata(sdata));

  // Conversion clock, 25 ns.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Count busy starts; a hang is cut short here.
  always @(negedge conversion_done) starts++;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Power down never ends, so the wait is bounded.
  task automatic settle();
    int i;
    i = 0;
    repeat (8) @(negedge clk_sys);
    while (conversion_done !== 1'b1 && i < 300) begin
      @(negedge clk_sys);
      i++;
    end
  endtask : settle

  task automatic t_reset();
    `CHK("done", 1'b1, conversion_done)
    `CHK("ready", 1'b0, output_ready_flag)
    `CHK("oe", 1'b0, serial_out_oe)
    `CHK("chan", 4'h0, mux_channel)
  endtask : t_reset

  task automatic t_modes();
    int b;
    for (int m = 0; m < 4; m++) begin
      b = starts;
      host.frame({m[1:0], 2'h0, 4'(m + 9)}, 13);
      settle();
      if (m == 1) begin
        `CHK("result", 13'h1A5B, host.got[12:0])
        `CHK("ready", 1'b1, output_ready_flag)
      end
      `CHK("mode", m[1:0], program_enable_n_mode)
      `CHK("chan", 4'(m + 9), mux_channel)
      `CHK("done", m != 3, conversion_done)
      `CHK("starts", b + 1, starts)
    end
    host.frame(8'h01, 13);
    settle();
  endtask : t_modes

  task automatic t_len();
    program_enable_n_value = 13'h0F31;
    host.frame(8'h13, 13);
    settle();
    program_enable_n_value = 13'h1C6E;
    host.frame(8'h23, 17);
    `CHK("word17", {13'h0F31, 4'h0}, host.got)
    settle();
    host.frame(8'h03, 9);
    `CHK("word9", 9'h1C6, host.got[8:0])
    `CHK("ready", 1'b1, output_ready_flag)
    settle();
  endtask : t_len

  task automatic t_readonly();
    int b;
    program_enable_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    b = starts;
    host.frame(8'hC7, 13);
    repeat (20) @(negedge clk_sys);
    `CHK("starts", b, starts)
    `CHK("chan", 4'h3, mux_channel)
    `CHK("result", 13'h1C6E, host.got[12:0])
    program_enable_n = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : t_readonly

  task automatic t_abort();
    int b;
    b = starts;
    host.frame(8'h04, 13);
    repeat (6) @(negedge clk_sys);
    program_enable_n_value = 13'h0ACE;
    host.frame(8'h06, 13);
    settle();
    `CHK("starts", b + 2, starts)
    `CHK("chan", 4'h6, mux_channel)
    program_enable_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    host.frame(8'h00, 13);
    `CHK("result", 13'h0ACE, host.got[12:0])
  endtask : t_abort

  initial begin
    reset_n = 1'b0;
    program_enable_n = 1'b0;
    program_enable_n_value = 13'h1A5B;
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    t_reset();
    t_modes();
    t_len();
    t_readonly();
    t_abort();
    close_out();
  end
endmodule : acsio_top_tb
